// [logic/vcc_core.sv]
// Contract
// - Hold current field scales standstill current, code 0 is 1/32, 31 is 32/32.
// - Run current field scales running current the same way, resets to 31.
// - Silent chopper with hold zero: freewheel or brake coils as selected.
// - Current reduction starts only after standstill and power-down delay.
// - Ramp delay 0 drops instantly; 1..15 gives value times 2^18 per step.
// - Power-down delay register counts standstill-to-power-down in 2^18 clocks.
// - Step interval counts clocks per 1/256 microstep, all ones on overflow.
// - Interval always refers to 1/256 steps regardless of resolution.
// - Threshold hysteresis: lower compare value is threshold*15/16 minus one.
// - Above threshold velocity switch to cycle chopper; zero threshold disables.
// - Internal velocity zero: motor moves only from the step input.
// - Nonzero velocity moves motor at that signed rate, steps echoed on index.
// - Read-only 10-bit microstep position; phase B offset by 256 entries.
// - Read-only signed 9-bit phase currents at bits 8..0 and 24..16, unscaled.
// - Ramp delay resets from 2-bit code selecting 1, 2, 4 or 8.
module vcc_core #(
  parameter int TICK_CYCLES = 2 ** 18
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Step and direction pins
  input wire logic step_pin,
  input wire logic dir_pin,
  // Static configuration
  input wire logic silent_enable,
  input wire logic standstill_brake,
  input wire logic [vcc_pkg::VCC_MRES_W-1:0] microstep_res,
  input wire logic [1:0] nv_ramp_code,
  input wire logic [vcc_pkg::VCC_CUR_W-1:0] nv_hold_current,
  // Register access from the serial frame decoder
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  output logic [31:0] reg_rd_data,
  output logic reg_rd_valid,
  // Driver outputs
  output logic [vcc_pkg::VCC_CUR_W-1:0] current_scale,
  output logic cycle_chopper,
  output logic coil_freewheel,
  output logic coil_brake,
  output logic standstill,
  output logic index_out,
  output logic microstep_event,
  output logic microstep_dir
);
  import vcc_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] step_sync;
    logic [1:0] dir_sync;
    logic step_prev;
    logic loaded;
    logic [VCC_CUR_W-1:0] hold_cur;
    logic [VCC_CUR_W-1:0] run_cur;
    logic [VCC_RAMP_W-1:0] ramp_dly;
    logic [VCC_PD_W-1:0] pd_delay;
    logic [VCC_INTERVAL_W-1:0] thr;
    logic [VCC_VEL_W-1:0] vel;
    logic [VCC_PERIOD_W-1:0] period;
    logic [VCC_INTERVAL_W-1:0] interval;
    logic stst;
    logic cyc;
    logic [VCC_POS_W-1:0] pos;
    logic [VCC_VEL_W-1:0] acc;
    logic index;
    logic ev;
    logic ev_dir;
    vcc_pd_t pd;
    logic [TICK_W-1:0] tick;
    logic [VCC_PD_W-1:0] dcnt;
    logic [VCC_CUR_W-1:0] cur;
    logic [31:0] rd_data;
    logic rd_valid;
  } vcc_state_t;

  vcc_state_t s_r;
  vcc_state_t s_nxt;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [VCC_MRES_W-1:0] clamp_mres(
    input logic [VCC_MRES_W-1:0] m
  );
    return (m > VCC_MRES_MAX) ? VCC_MRES_MAX : m;
  endfunction

  // Period in 1/256 units, saturated to the interval width
  function automatic logic [VCC_INTERVAL_W-1:0] per_usteps(
    input logic [VCC_PERIOD_W-1:0] p,
    input logic [VCC_MRES_W-1:0] m
  );
    logic [VCC_PERIOD_W-1:0] q;
    q = p >> m;
    if (q >= VCC_PERIOD_W'(VCC_INTERVAL_MAX)) begin
      return VCC_INTERVAL_MAX;
    end
    return q[VCC_INTERVAL_W-1:0];
  endfunction

  // threshold*15/16 - 1, floored at zero
  function automatic logic [VCC_INTERVAL_W-1:0] lower_cmp(
    input logic [VCC_INTERVAL_W-1:0] t
  );
    logic [VCC_INTERVAL_W-1:0] r;
    r = t - (t >> 4);
    return (r == '0) ? '0 : r - VCC_INTERVAL_W'(1);
  endfunction

  // ---------------------------------------------------------------
  // Sine table readback
  // ---------------------------------------------------------------
  logic signed [VCC_PHASE_W-1:0] phase_a_current;
  logic signed [VCC_PHASE_W-1:0] phase_b_current;
  logic [VCC_POS_W-1:0] pos_b;

  assign pos_b = s_r.pos + VCC_PHASE_OFFSET;

  vcc_sine u_sine_a (
    .position(s_r.pos),
    .value(phase_a_current)
  );

  vcc_sine u_sine_b (
    .position(pos_b),
    .value(phase_b_current)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic step_s;
  logic step_edge;
  logic int_mode;
  logic [VCC_VEL_W-1:0] vel_mag;
  logic [VCC_VEL_W:0] acc_sum;
  logic int_step;
  logic move;
  logic move_dir;
  logic [VCC_MRES_W-1:0] mres;
  logic [VCC_POS_W-1:0] pos_inc;
  logic tick_now;
  logic [VCC_PD_W-1:0] ramp_len;

  always_comb begin
    s_nxt = s_r;
    s_nxt.index = 1'b0;
    s_nxt.ev = 1'b0;
    s_nxt.rd_valid = 1'b0;

    // Pin synchronisers
    s_nxt.step_sync = {s_r.step_sync[0], step_pin};
    s_nxt.dir_sync = {s_r.dir_sync[0], dir_pin};
    step_s = s_r.step_sync[1];
    s_nxt.step_prev = step_s;
    step_edge = step_s & ~s_r.step_prev;

    // Nonvolatile defaults are taken once after reset release
    if (!s_r.loaded) begin
      s_nxt.loaded = 1'b1;
      s_nxt.hold_cur = nv_hold_current;
      s_nxt.ramp_dly = VCC_RAMP_W'(4'h1 << nv_ramp_code);
    end

    // Velocity generator: carry of a phase accumulator is one step
    int_mode = (s_r.vel != '0);
    vel_mag = s_r.vel[VCC_VEL_W-1] ? -s_r.vel : s_r.vel;
    acc_sum = {1'b0, s_r.acc} + {1'b0, vel_mag};
    int_step = 1'b0;
    if (int_mode) begin
      s_nxt.acc = acc_sum[VCC_VEL_W-1:0];
      int_step = acc_sum[VCC_VEL_W];
    end else begin
      s_nxt.acc = '0;
    end
    // External steps only count while the generator is idle
    move = int_mode ? int_step : step_edge;
    move_dir = int_mode ? ~s_r.vel[VCC_VEL_W-1] : s_r.dir_sync[1];
    s_nxt.index = int_step;

    // Microstep position
    mres = clamp_mres(microstep_res);
    pos_inc = VCC_POS_W'(1) << mres;
    if (move) begin
      s_nxt.pos = move_dir ? s_r.pos + pos_inc : s_r.pos - pos_inc;
      s_nxt.ev = 1'b1;
      s_nxt.ev_dir = move_dir;
    end

    // Step interval, scaled to 1/256 steps
    if (move) begin
      s_nxt.interval = per_usteps(s_r.period, mres);
      s_nxt.period = VCC_PERIOD_W'(1);
      s_nxt.stst = 1'b0;
    end else begin
      if (s_r.period != '1) begin
        s_nxt.period = s_r.period + VCC_PERIOD_W'(1);
      end
      if (per_usteps(s_r.period, mres) == VCC_INTERVAL_MAX) begin
        s_nxt.interval = VCC_INTERVAL_MAX;
        s_nxt.stst = 1'b1;
      end
    end

    // Chopper selection with hysteresis
    if (!silent_enable || s_r.thr == '0 || s_r.stst) begin
      s_nxt.cyc = !silent_enable;
    end else if (!s_r.cyc && s_r.interval <= lower_cmp(s_r.thr)) begin
      s_nxt.cyc = 1'b1;
    end else if (s_r.cyc && s_r.interval >= s_r.thr) begin
      s_nxt.cyc = 1'b0;
    end

    // Power-down sequencer, ticks restart on entering the delay and ramp states
    tick_now = (s_r.tick == TICK_LAST);
    s_nxt.tick = tick_now ? '0 : s_r.tick + TICK_W'(1);
    ramp_len = VCC_PD_W'(s_r.ramp_dly);
    case (s_r.pd)
      VCC_PD_RUN: begin
        s_nxt.cur = s_r.run_cur;
        if (s_r.stst) begin
          s_nxt.pd = VCC_PD_DELAY;
          s_nxt.tick = '0;
          s_nxt.dcnt = '0;
        end
      end
      VCC_PD_DELAY: begin
        // A run level written while waiting must still apply
        s_nxt.cur = s_r.run_cur;
        if (s_r.dcnt >= s_r.pd_delay) begin
          s_nxt.pd = VCC_PD_RAMP;
          s_nxt.tick = '0;
          s_nxt.dcnt = '0;
        end else if (tick_now) begin
          s_nxt.dcnt = s_r.dcnt + VCC_PD_W'(1);
        end
      end
      VCC_PD_RAMP: begin
        if (s_r.ramp_dly == '0 || s_r.cur <= s_r.hold_cur) begin
          s_nxt.cur = s_r.hold_cur;
          s_nxt.pd = VCC_PD_HOLD;
        end else if (tick_now) begin
          if (s_r.dcnt + VCC_PD_W'(1) >= ramp_len) begin
            s_nxt.cur = s_r.cur - VCC_CUR_W'(1);
            s_nxt.dcnt = '0;
          end else begin
            s_nxt.dcnt = s_r.dcnt + VCC_PD_W'(1);
          end
        end
      end
      VCC_PD_HOLD: begin
        s_nxt.cur = s_r.hold_cur;
      end
      default: begin
        s_nxt.pd = VCC_PD_RUN;
      end
    endcase
    // Motion always wins back the run level
    if (move) begin
      s_nxt.pd = VCC_PD_RUN;
      s_nxt.cur = s_r.run_cur;
    end

    // Register writes
    if (reg_wr_en) begin
      case (reg_addr)
        VCC_ADDR_CURRENT_LEVELS: begin
          s_nxt.hold_cur = reg_wr_data[VCC_HOLD_LSB +: VCC_CUR_W];
          s_nxt.run_cur = reg_wr_data[VCC_RUN_LSB +: VCC_CUR_W];
          s_nxt.ramp_dly = reg_wr_data[VCC_RAMP_LSB +: VCC_RAMP_W];
          s_nxt.loaded = 1'b1;
        end
        VCC_ADDR_POWERDOWN_DELAY: begin
          s_nxt.pd_delay = reg_wr_data[VCC_PD_W-1:0];
        end
        VCC_ADDR_SILENT_THRESHOLD: begin
          s_nxt.thr = reg_wr_data[VCC_INTERVAL_W-1:0];
        end
        VCC_ADDR_INTERNAL_VELOCITY: begin
          s_nxt.vel = reg_wr_data[VCC_VEL_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads; write-only and unmapped indices read zero
    if (reg_rd_en) begin
      s_nxt.rd_valid = 1'b1;
      s_nxt.rd_data = '0;
      case (reg_addr)
        VCC_ADDR_STEP_INTERVAL: begin
          s_nxt.rd_data[VCC_INTERVAL_W-1:0] = s_r.interval;
        end
        VCC_ADDR_MICROSTEP_POSITION: begin
          s_nxt.rd_data[VCC_POS_W-1:0] = s_r.pos;
        end
        VCC_ADDR_MICROSTEP_CURRENTS: begin
          s_nxt.rd_data[VCC_PHASE_B_CURRENT_LSB +: VCC_PHASE_W] = phase_b_current;
          s_nxt.rd_data[VCC_PHASE_A_CURRENT_LSB +: VCC_PHASE_W] = phase_a_current;
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.run_cur <= VCC_RUN_RESET;
      s_r.cur <= VCC_RUN_RESET;
      s_r.pd_delay <= VCC_PD_RESET;
      s_r.interval <= VCC_INTERVAL_MAX;
      s_r.period <= '1;
      s_r.stst <= 1'b1;
      s_r.pd <= VCC_PD_RUN;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Standstill option only applies once the hold level is reached
  logic hold_zero;
  assign hold_zero = silent_enable && !s_r.cyc && s_r.pd == VCC_PD_HOLD &&
                     s_r.hold_cur == '0;
  assign coil_freewheel = hold_zero && !standstill_brake;
  assign coil_brake = hold_zero && standstill_brake;
  assign current_scale = s_r.cur;
  assign cycle_chopper = s_r.cyc;
  assign standstill = s_r.stst;
  assign index_out = s_r.index;
  assign microstep_event = s_r.ev;
  assign microstep_dir = s_r.ev_dir;
  assign reg_rd_data = s_r.rd_data;
  assign reg_rd_valid = s_r.rd_valid;

endmodule

// [logic/vcc_pkg.sv]
package vcc_pkg;

  // ---------------------------------------------------------------
  // Register indices on the access port
  // ---------------------------------------------------------------
  localparam logic [6:0] VCC_ADDR_CURRENT_LEVELS = 7'h10;
  localparam logic [6:0] VCC_ADDR_POWERDOWN_DELAY = 7'h11;
  localparam logic [6:0] VCC_ADDR_STEP_INTERVAL = 7'h12;
  localparam logic [6:0] VCC_ADDR_SILENT_THRESHOLD = 7'h13;
  localparam logic [6:0] VCC_ADDR_INTERNAL_VELOCITY = 7'h22;
  localparam logic [6:0] VCC_ADDR_MICROSTEP_POSITION = 7'h6a;
  localparam logic [6:0] VCC_ADDR_MICROSTEP_CURRENTS = 7'h6b;

  // ---------------------------------------------------------------
  // Field layout of current_levels
  // ---------------------------------------------------------------
  localparam int VCC_HOLD_LSB = 0;
  localparam int VCC_RUN_LSB = 8;
  localparam int VCC_RAMP_LSB = 16;
  localparam int VCC_CUR_W = 5;
  localparam int VCC_RAMP_W = 4;

  // Field layout of microstep_currents
  localparam int VCC_PHASE_B_CURRENT_LSB = 0;
  localparam int VCC_PHASE_A_CURRENT_LSB = 16;
  localparam int VCC_PHASE_W = 9;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int VCC_PD_W = 8;
  localparam int VCC_INTERVAL_W = 20;
  localparam int VCC_VEL_W = 24;
  localparam int VCC_POS_W = 10;
  localparam int VCC_MRES_W = 4;
  localparam int VCC_PERIOD_W = 28;

  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam logic [4:0] VCC_RUN_RESET = 5'h1f;
  localparam logic [7:0] VCC_PD_RESET = 8'h14;
  localparam logic [19:0] VCC_INTERVAL_MAX = 20'hf_ffff;
  localparam logic [3:0] VCC_MRES_MAX = 4'h8;
  localparam logic [9:0] VCC_PHASE_OFFSET = 10'h100;

  // Power-down time base: one tick is 2^18 clocks
  localparam int VCC_TICK_LOG2 = 18;

  typedef enum logic [1:0] {
    VCC_PD_RUN,
    VCC_PD_DELAY,
    VCC_PD_RAMP,
    VCC_PD_HOLD
  } vcc_pd_t;

endpackage

// [logic/vcc_sine.sv]
module vcc_sine (
  // Table position
  input wire logic [9:0] position,
  // Signed table value
  output logic signed [8:0] value
);
  import vcc_pkg::*;

  // ---------------------------------------------------------------
  // Quarter wave, 33 points plus a guard, linearly interpolated
  // ---------------------------------------------------------------
  // Coarse points keep the table small; error stays below one and a half lsb
  localparam logic [7:0] QTAB [0:33] = '{
    8'h00, 8'h0d, 8'h19, 8'h25, 8'h32, 8'h3e, 8'h4a, 8'h56,
    8'h62, 8'h6d, 8'h78, 8'h83, 8'h8e, 8'h98, 8'ha2, 8'hab,
    8'hb4, 8'hbd, 8'hc5, 8'hcd, 8'hd4, 8'hdb, 8'he1, 8'he7,
    8'hec, 8'hf0, 8'hf4, 8'hf7, 8'hfa, 8'hfc, 8'hfe, 8'hff,
    8'hff, 8'hff
  };

  logic [8:0] arg;
  logic [5:0] seg;
  logic [2:0] frac;
  logic [7:0] lo;
  logic [7:0] hi;
  logic [10:0] step_part;
  logic [7:0] mag;

  always_comb begin
    arg = position[8] ? (9'h100 - {1'b0, position[7:0]})
                      : {1'b0, position[7:0]};
    seg = arg[8:3];
    frac = arg[2:0];
    lo = QTAB[seg];
    hi = QTAB[seg + 6'h01];
    step_part = 11'((hi - lo) * frac);
    mag = 8'(lo + step_part[10:3]);
    value = position[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  end

endmodule

// [sim/vcc_core_sva.sv]
module vcc_core_sva #(
  parameter int TICK_CYCLES = 2 ** 18
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Configuration
  input wire logic silent_enable,
  input wire logic standstill_brake,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_addr,
  input wire logic [31:0] reg_wr_data,
  input wire logic [31:0] reg_rd_data,
  input wire logic reg_rd_valid,
  // Driver outputs
  input wire logic [vcc_pkg::VCC_CUR_W-1:0] current_scale,
  input wire logic cycle_chopper,
  input wire logic coil_freewheel,
  input wire logic coil_brake,
  input wire logic standstill,
  input wire logic index_out,
  input wire logic microstep_event
);
  import vcc_pkg::*;
  // ----------------------------------------------------------------
  // Shadow of the write-only registers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] up;
    logic vz;
    logic tz;
    logic [4:0] run;
    logic [7:0] pd;
    logic [15:0] cnt;
  } vcc_chk_t;
  vcc_chk_t s_r;
  vcc_chk_t s_nxt;
  logic rd_ss;
  logic wr;
  assign rd_ss = reg_rd_en && standstill && reg_addr == VCC_ADDR_STEP_INTERVAL;
  assign wr = reg_wr_en;
  always_comb begin
    s_nxt = s_r;
    if (s_r.up != 2'h3) s_nxt.up = s_r.up + 2'h1;
    if (!standstill) s_nxt.cnt = 16'h0000;
    else if (s_r.cnt != 16'hffff) s_nxt.cnt = s_r.cnt + 16'h0001;
    if (wr && reg_addr == VCC_ADDR_CURRENT_LEVELS) s_nxt.run = reg_wr_data[12:8];
    if (wr && reg_addr == VCC_ADDR_POWERDOWN_DELAY) s_nxt.pd = reg_wr_data[7:0];
    if (wr && reg_addr == VCC_ADDR_SILENT_THRESHOLD) begin
      s_nxt.tz = reg_wr_data[19:0] == 20'h0_0000;
    end
    if (wr && reg_addr == VCC_ADDR_INTERNAL_VELOCITY) begin
      s_nxt.vz = reg_wr_data[23:0] == 24'h00_0000;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) s_r <= {2'h0, 1'b1, 1'b1, VCC_RUN_RESET, VCC_PD_RESET, 16'h0000};
    else s_r <= s_nxt;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_rdv; s_r.up == 2'h3 |-> reg_rd_valid == $past(reg_rd_en); endproperty
  a_rdv: assert property (p_rdv) else $error("read answer mistimed");
  property p_sst; reg_rd_valid && $past(rd_ss) |-> reg_rd_data[19:0] == VCC_INTERVAL_MAX; endproperty
  a_sst: assert property (p_sst) else $error("interval not saturated");
  property p_clr; microstep_event |=> !standstill; endproperty
  a_clr: assert property (p_clr) else $error("standstill kept");
  property p_run; microstep_event |-> ##[1:2] current_scale == s_r.run; endproperty
  a_run: assert property (p_run) else $error("no run current");
  // Writes may lower the run level, so they are masked out here
  property p_pdt;
    s_r.up == 2'h3 && current_scale < $past(current_scale) && !$past(wr)
      && !$past(wr, 2) && !$past(wr, 3)
      |-> standstill && int'(s_r.cnt) + 4 >= int'(s_r.pd) * TICK_CYCLES;
  endproperty
  a_pdt: assert property (p_pdt) else $error("early current drop");
  property p_idx; s_r.vz && $past(s_r.vz) |-> !index_out; endproperty
  a_idx: assert property (p_idx) else $error("index while idle");
  property p_chz;
    s_r.tz && $past(s_r.tz) && silent_enable && $past(silent_enable) |-> !cycle_chopper;
  endproperty
  a_chz: assert property (p_chz) else $error("switch not disabled");
  property p_slo;
    s_r.up == 2'h3 && !silent_enable && !$past(silent_enable) |-> cycle_chopper;
  endproperty
  a_slo: assert property (p_slo) else $error("silent chopper kept");
  property p_brk; coil_brake |-> standstill_brake && silent_enable && !coil_freewheel; endproperty
  a_brk: assert property (p_brk) else $error("brake misused");
  property p_fwl; coil_freewheel |-> !standstill_brake && silent_enable; endproperty
  a_fwl: assert property (p_fwl) else $error("freewheel misused");
endmodule

bind vcc_core vcc_core_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.clk_sys, .reset_n,
  .silent_enable, .standstill_brake, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data,
  .reg_rd_data, .reg_rd_valid, .current_scale, .cycle_chopper, .coil_freewheel,
  .coil_brake, .standstill, .index_out, .microstep_event);

// [sim/vcc_core_tb.sv]
module vcc_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import vcc_pkg::*;
  localparam int TK = 16;
  logic clk_sys, reset_n, silent_enable, standstill_brake;
  logic [3:0] microstep_res;
  logic [1:0] nv_ramp_code;
  logic [4:0] nv_hold_current, current_scale;
  logic step_pin, dir_pin, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [6:0] reg_addr;
  logic [31:0] reg_wr_data, reg_rd_data;
  logic cycle_chopper, coil_freewheel, coil_brake, standstill;
  logic index_out, microstep_event, microstep_dir;
  logic [63:0] exp_q[$];
  logic [63:0] e;
  int error_cnt, checked, ix_n, ev_n, p, ps, mm;
  int pt[5] = '{330, 310, 290, 310, 330};
  logic ex[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  vcc_host hst (.clk_sys, .step_pin, .dir_pin, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wr_data);
  vcc_core #(.TICK_CYCLES(TK)) dut_u (.clk_sys, .reset_n, .step_pin, .dir_pin,
    .silent_enable, .standstill_brake, .microstep_res, .nv_ramp_code,
    .nv_hold_current, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data,
    .reg_rd_data, .reg_rd_valid, .current_scale, .cycle_chopper,
    .coil_freewheel, .coil_brake, .standstill, .index_out,
    .microstep_event, .microstep_dir);
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  always @(negedge clk_sys) begin
    if (index_out === 1'b1) ix_n++;
    if (microstep_event === 1'b1) ev_n++;
    if (reg_rd_valid === 1'b1) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 64'hffff_ffff_ffff_fffe;
      chk(reg_rd_data & e[63:32], e[31:0]);
    end
  end
  task automatic nx(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic rd(input logic [6:0] a, input logic [31:0] m, input logic [31:0] v);
    exp_q.push_back({m, v});
    hst.acc(1'b0, a, 32'h0000_0000);
  endtask
  task automatic wchg(input int lim, output int n);
    logic [4:0] v;
    v = current_scale;
    n = 0;
    while (current_scale === v && n < lim) begin
      nx(1);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      $display("[ERR] t=%0t waited=%h limit=%h", $time, n, lim);
      conclude();
    end
  endtask
  task automatic rst(input logic [1:0] c, input logic [4:0] h);
    nx(1);
    reset_n = 1'b0;
    nv_ramp_code = c;
    nv_hold_current = h;
    nx(10);
    reset_n = 1'b1;
  endtask
  // First drop may land up to one ramp period after the delay ends
  task automatic pdw(input int pd, input int rp, input logic [4:0] run, input logic [4:0] hold);
    int t;
    logic [4:0] pv;
    nx(3);
    chk(32'(current_scale), 32'(run));
    wchg(pd * TK + rp * TK + 20, t);
    chk(32'(t > pd * TK - 20), 32'h0000_0001);
    if (rp == 0) chk(32'(current_scale), 32'(hold));
    else chk(32'(current_scale), 32'(run - 5'h01));
    while (current_scale !== hold) begin
      pv = current_scale;
      wchg(rp * TK + 4, t);
      chk(32'(t), 32'(rp * TK));
      chk(32'(current_scale), 32'(pv - 5'h01));
    end
    nx(40);
    chk(32'(current_scale), 32'(hold));
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {reset_n, standstill_brake, microstep_res, nv_ramp_code} = 8'h00;
    silent_enable = 1'b1;
    nv_hold_current = 5'h00;
    {error_cnt, checked, ix_n, ev_n} = {32'h0, 32'h0, 32'h0, 32'h0};
    void'($urandom(32'he616));
    for (int c = 0; c < 4; c++) begin
      rst(2'(c), 5'h1c);
      pdw(20, 1 << c, 5'h1f, 5'h1c);
    end
    $display("test strap ramp done");
    rst(2'h0, 5'h1f);
    hst.acc(1'b1, VCC_ADDR_CURRENT_LEVELS, 32'h0000_1400);
    pdw(20, 0, 5'h14, 5'h00);
    standstill_brake = 1'b1;
    nx(1);
    chk({coil_brake, coil_freewheel}, 2'b10);
    standstill_brake = 1'b0;
    nx(1);
    chk({coil_brake, coil_freewheel}, 2'b01);
    rd(VCC_ADDR_STEP_INTERVAL, 32'hffff_ffff, 32'h000f_ffff);
    rd(VCC_ADDR_CURRENT_LEVELS, 32'hffff_ffff, 32'h0000_0000);
    rd(7'h05, 32'hffff_ffff, 32'h0000_0000);
    // Position 0: phase A at zero crossing, phase B at its peak
    rd(VCC_ADDR_MICROSTEP_CURRENTS, 32'hffff_ffff, 32'h0000_00ff);
    hst.acc(1'b1, VCC_ADDR_STEP_INTERVAL, 32'h0000_0000);
    rd(VCC_ADDR_STEP_INTERVAL, 32'hffff_ffff, 32'h000f_ffff);
    hst.step(64, 1'b1);
    chk({standstill, current_scale}, 6'h14);
    $display("test hold zero done");
    // One step so far since the last reset; resolution 9 clamps to 8
    ps = 1;
    for (int m = 0; m <= 9; m++) begin
      microstep_res = 4'(m);
      mm = m > 8 ? 8 : m;
      p = 256 + 2 * ($urandom % 128);
      ps = ps + 3 * (1 << mm);
      repeat (3) hst.step(p, 1'b1);
      rd(VCC_ADDR_STEP_INTERVAL, 32'hffff_ffff, 32'(p >> mm));
      rd(VCC_ADDR_MICROSTEP_POSITION, 32'hffff_ffff, 32'(ps % 1024));
      rd(VCC_ADDR_MICROSTEP_CURRENTS, 32'hfe00_fe00, 32'h0000_0000);
    end
    $display("test step interval done");
    microstep_res = 4'h0;
    hst.acc(1'b1, VCC_ADDR_POWERDOWN_DELAY, 32'h0000_0002);
    // Threshold 320: up at 299 and below, back down at 320 and above
    hst.acc(1'b1, VCC_ADDR_SILENT_THRESHOLD, 32'h0000_0140);
    for (int i = 0; i < 5; i++) begin
      repeat (3) hst.step(pt[i], 1'b1);
      chk(32'(cycle_chopper), 32'(ex[i]));
    end
    hst.acc(1'b1, VCC_ADDR_SILENT_THRESHOLD, 32'h0000_0000);
    repeat (3) hst.step(290, 1'b1);
    chk(32'(cycle_chopper), 32'h0000_0000);
    silent_enable = 1'b0;
    nx(2);
    chk(32'(cycle_chopper), 32'h0000_0001);
    silent_enable = 1'b1;
    $display("test chopper select done");
    hst.acc(1'b1, VCC_ADDR_INTERNAL_VELOCITY, 32'h0040_0000);
    nx(4);
    ix_n = 0;
    nx(64);
    chk({31'h0, ix_n >= 15 && ix_n <= 17}, 32'h0000_0001);
    chk(32'(microstep_dir), 32'h0000_0001);
    hst.acc(1'b1, VCC_ADDR_INTERNAL_VELOCITY, 32'h00c0_0000);
    nx(8);
    chk(32'(microstep_dir), 32'h0000_0000);
    hst.acc(1'b1, VCC_ADDR_INTERNAL_VELOCITY, 32'h0000_0000);
    nx(4);
    {ix_n, ev_n} = {32'h0, 32'h0};
    hst.step(64, 1'b1);
    chk({ix_n[15:0], ev_n[14:0], microstep_dir}, 32'h0000_0003);
    $display("test internal velocity done");
    nx(4);
    chk(32'(exp_q.size()), 32'h0000_0000);
    conclude();
  end
endmodule

// [sim/vcc_host.sv]
module vcc_host (
  // Clock
  input wire logic clk_sys,
  // Step and direction
  output logic step_pin,
  output logic dir_pin,
  // Register strobes
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [6:0] reg_addr,
  output logic [31:0] reg_wr_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    step_pin = 1'b0;
    dir_pin = 1'b1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 7'h00;
    reg_wr_data = 32'h0000_0000;
  end
  // Released lines show the inverse so a stale value cannot pass
  task automatic acc(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    #1;
    reg_wr_en = w;
    reg_rd_en = !w;
    reg_addr = a;
    reg_wr_data = d;
    @(posedge clk_sys);
    #1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask
  // Each pin level lasts half the period; with an odd period the low level gets the extra clock
  task automatic step(input int p, input logic d);
    @(posedge clk_sys);
    #1;
    dir_pin = d;
    step_pin = 1'b1;
    repeat (p / 2) @(posedge clk_sys);
    #1;
    step_pin = 1'b0;
    repeat (p - p / 2 - 1) @(posedge clk_sys);
    #1;
  endtask
endmodule
